// ==== rtl/ics_pkg.sv ====
// shared constants and types for the clock mode controller
package ics_pkg;
	typedef enum logic [2:0] {
		ICS_LL_INT,
		ICS_LL_EXT,
		ICS_BYP_INT,
		ICS_BYP_EXT,
		ICS_BYP_INT_LP,
		ICS_BYP_EXT_LP,
		ICS_STOP
	} ics_mode_e;

	localparam logic [1:0] CLKSEL_LOOP     = 2'h0;
	localparam logic [1:0] CLKSEL_INTREF   = 2'h1;
	localparam logic [1:0] CLKSEL_EXTREF   = 2'h2;
	localparam int         LOOP_MULT       = 512;
	localparam int         SWITCH_CYCLES   = 4;
	localparam int         RELOCK_CYCLES   = 4;
	localparam int         ALIVE_TIMEOUT   = 64;
	localparam logic [1:0] CLKSEL_RESET    = 2'h0;
	localparam logic       REFINT_RESET    = 1'b1;
endpackage

// ==== rtl/ics_clock_unit.sv ====
// clock source mode control, source switching and clock gating
`timescale 1ns/10ps

module ics_clock_unit #(
	parameter int BUS_DIV_W = 2,
	parameter int REF_DIV_W = 3
) (
	input  wire logic                 clock,
	input  wire logic                 sys_rst,
	input  wire logic                 int_ref_tick,
	input  wire logic                 ext_ref_tick,
	input  wire logic                 loop_tick,
	input  wire logic                 div_ref_tick,
	input  wire logic [1:0]           clock_select,
	input  wire logic                 ref_select_internal,
	input  wire logic [REF_DIV_W-1:0] ref_divider,
	input  wire logic                 low_power_sel,
	input  wire logic                 debug_background_mode,
	input  wire logic                 stop_req,
	input  wire logic                 int_ref_clock_en,
	input  wire logic                 int_ref_stop_en,
	input  wire logic                 ext_ref_clock_en,
	input  wire logic                 ext_ref_stop_en,
	input  wire logic [BUS_DIV_W-1:0] bus_divider,
	output logic                      main_clock_out,
	output logic                      bus_clock_out,
	output logic                      debug_lowspeed_clock,
	output logic                      int_ref_clock_out,
	output logic                      ext_ref_clock_out,
	output logic                      loop_enable,
	output logic                      loop_relock,
	output logic [REF_DIV_W-1:0]      loop_ref_divider,
	output logic [1:0]                active_source,
	output logic [2:0]                mode_state
);
	ics_pkg::ics_mode_e mode_q, mode_d;
	logic [1:0]  src_q;
	logic [1:0]  pend_q;
	logic [3:0]  seen_q;
	logic [6:0]  wait_q;
	logic        refsel_q;
	logic [3:0]  relock_q;
	logic [7:0]  bus_cnt_q;
	logic        main_q, bus_q, dbg_q, iref_q, eref_q;

	function automatic logic src_tick(input logic [1:0] s, input logic lt, input logic it, input logic et);
		if (s == ics_pkg::CLKSEL_LOOP) return lt;
		else if (s == ics_pkg::CLKSEL_INTREF) return it;
		else return et;
	endfunction

	wire logic want_lp   = low_power_sel && !debug_background_mode;
	wire logic in_stop   = (mode_q == ics_pkg::ICS_STOP);
	wire logic new_tick  = src_tick(pend_q, loop_tick, int_ref_tick, ext_ref_tick);
	wire logic cur_tick  = src_tick(src_q, loop_tick, int_ref_tick, ext_ref_tick);
	wire logic loop_mode = (mode_q == ics_pkg::ICS_LL_INT) || (mode_q == ics_pkg::ICS_LL_EXT);
	wire logic [7:0] bus_div_n = 8'((1 << bus_divider) - 1);

	// mode follows the effective source so the state never leads the glitch-free switch
	always_comb begin
		mode_d = mode_q;
		if (stop_req) begin
			mode_d = ics_pkg::ICS_STOP;
		end else begin
			case (src_q)
				ics_pkg::CLKSEL_LOOP: begin
					mode_d = refsel_q ? ics_pkg::ICS_LL_INT : ics_pkg::ICS_LL_EXT;
				end
				ics_pkg::CLKSEL_INTREF: begin
					mode_d = want_lp ? ics_pkg::ICS_BYP_INT_LP : ics_pkg::ICS_BYP_INT;
				end
				default: begin
					if (!refsel_q && want_lp) begin
						mode_d = ics_pkg::ICS_BYP_EXT_LP;
					end else begin
						mode_d = ics_pkg::ICS_BYP_EXT;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) mode_q <= ics_pkg::ICS_LL_INT;
		else mode_q <= mode_d;
	end

	// 11 has no source of its own and falls back to the external reference
	wire logic [1:0] sel_eff   = (clock_select == 2'h3) ? ics_pkg::CLKSEL_EXTREF : clock_select;
	wire logic       sel_new   = (sel_eff != pend_q);
	wire logic       switching = (pend_q != src_q);
	wire logic       seen_full = (seen_q == 4'(ics_pkg::SWITCH_CYCLES));
	wire logic       gave_up   = (wait_q == 7'(ics_pkg::ALIVE_TIMEOUT));

	// source switch: count edges of pending source, give up if it stays dead
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			src_q  <= ics_pkg::CLKSEL_RESET;
			pend_q <= ics_pkg::CLKSEL_RESET;
		end else if (sel_new) begin
			pend_q <= sel_eff;
		end else if (switching) begin
			if (seen_full && cur_tick) begin
				src_q <= pend_q;
			end else if (gave_up) begin
				pend_q <= src_q;
			end
		end
	end

	// count saturates so the switch can wait for a whole tick of the old source
	always_ff @(posedge clock) begin
		if (sys_rst || sel_new || !switching || gave_up) begin
			seen_q <= '0;
		end else if (new_tick && !seen_full) begin
			seen_q <= seen_q + 4'h1;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst || sel_new || !switching || gave_up) begin
			wait_q <= '0;
		end else begin
			wait_q <= wait_q + 7'h1;
		end
	end

	wire logic ref_changed = (refsel_q != ref_select_internal);
	wire logic relock_last = (relock_q == 4'h1);

	// reference select change restarts the lock after a few divided reference cycles
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			refsel_q    <= ics_pkg::REFINT_RESET;
			relock_q    <= '0;
			loop_relock <= 1'b0;
		end else begin
			refsel_q    <= ref_select_internal;
			loop_relock <= 1'b0;
			if (ref_changed) relock_q <= 4'(ics_pkg::RELOCK_CYCLES);
			else if (relock_q != 4'h0 && div_ref_tick) begin
				relock_q <= relock_q - 4'h1;
				if (relock_last) loop_relock <= 1'b1;
			end
		end
	end

	wire logic run_main = !in_stop && cur_tick;
	wire logic bus_wrap = (bus_cnt_q >= bus_div_n);
	wire logic lp_mode  = (mode_q == ics_pkg::ICS_BYP_EXT_LP) || (mode_q == ics_pkg::ICS_BYP_INT_LP);
	wire logic run_dbg  = !in_stop && !lp_mode && loop_tick;
	wire logic run_iref = int_ref_tick && int_ref_clock_en && (!in_stop || int_ref_stop_en);
	wire logic run_eref = ext_ref_tick && ext_ref_clock_en && (!in_stop || ext_ref_stop_en);

	// outputs toggle on their ticks, debug only outside low power; stop freezes them, except a reference output whose clock and stop enables are both set
	always_ff @(posedge clock) begin
		if (sys_rst) main_q <= 1'b0;
		else if (run_main) main_q <= ~main_q;
	end

	// a new divide ratio is compared on the next tick, no resync
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			bus_cnt_q <= '0;
			bus_q     <= 1'b0;
		end else if (run_main && bus_wrap) begin
			bus_cnt_q <= '0;
			bus_q     <= ~bus_q;
		end else if (run_main) begin
			bus_cnt_q <= bus_cnt_q + 8'h1;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) dbg_q <= 1'b0;
		else if (run_dbg) dbg_q <= ~dbg_q;
	end

	always_ff @(posedge clock) begin
		if (sys_rst) iref_q <= 1'b0;
		else if (run_iref) iref_q <= ~iref_q;
	end

	always_ff @(posedge clock) begin
		if (sys_rst) eref_q <= 1'b0;
		else if (run_eref) eref_q <= ~eref_q;
	end

	assign main_clock_out       = main_q;
	assign bus_clock_out        = bus_q;
	assign debug_lowspeed_clock = dbg_q;
	assign int_ref_clock_out    = iref_q;
	assign ext_ref_clock_out    = eref_q;
	assign loop_enable          = loop_mode || (mode_q == ics_pkg::ICS_BYP_INT) || (mode_q == ics_pkg::ICS_BYP_EXT);
	assign loop_ref_divider     = ref_divider;
	assign active_source        = src_q;
	assign mode_state           = mode_q;
endmodule

// ==== tb/ics_osc_model.sv ====
// reference and loop oscillator ticks seen by the clock unit
`timescale 1ns/10ps
module ics_osc_model (
	input  wire logic clock,
	input  wire logic sys_rst,
	input  wire logic int_alive,
	output logic      int_ref_tick,
	output logic      ext_ref_tick,
	output logic      loop_tick,
	output logic      div_ref_tick
);
	logic [2:0] cnt_q;
	always_ff @(posedge clock) begin
		if (sys_rst) cnt_q <= 3'h0;
		else cnt_q <= cnt_q + 3'h1;
	end
	// internal ref can be stopped to model a dead source
	assign int_ref_tick = int_alive && cnt_q[1:0] == 2'h3;
	assign ext_ref_tick = cnt_q[0];
	assign loop_tick    = !cnt_q[0];
	assign div_ref_tick = cnt_q == 3'h5;
endmodule

// ==== tb/ics_properties.sv ====
// assertions and covers for the clock mode controller
`timescale 1ns/10ps
module ics_props (
	input wire logic       clock,
	input wire logic       sys_rst,
	input wire logic [1:0] clock_select,
	input wire logic       ref_select_internal,
	input wire logic       low_power_sel,
	input wire logic       debug_background_mode,
	input wire logic       stop_req,
	input wire logic       int_ref_clock_en,
	input wire logic       int_ref_stop_en,
	input wire logic       ext_ref_clock_en,
	input wire logic       ext_ref_stop_en,
	input wire logic       main_clock_out,
	input wire logic       debug_lowspeed_clock,
	input wire logic       int_ref_clock_out,
	input wire logic       ext_ref_clock_out,
	input wire logic       loop_enable,
	input wire logic       loop_relock,
	input wire logic [1:0] active_source,
	input wire logic [2:0] mode_state
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	wire stp = stop_req && mode_state == 3'h6;
	stop_enter_a: assert property (stop_req |=> mode_state == 3'h6) else $error("stop not entered");
	stop_freeze_a: assert property (stp |=> $stable(main_clock_out) && $stable(debug_lowspeed_clock) && !loop_enable)
		else $error("clock moved in stop");
	int_stop_a: assert property (stp && !(int_ref_clock_en && int_ref_stop_en) |=> $stable(int_ref_clock_out))
		else $error("int ref ran in stop");
	ext_stop_a: assert property (stp && !(ext_ref_clock_en && ext_ref_stop_en) |=> $stable(ext_ref_clock_out))
		else $error("ext ref ran in stop");
	lp_loop_a: assert property (mode_state == 3'h5 |-> !loop_enable) else $error("loop on in low power");
	lp_entry_a: assert property ((active_source == 2'h2 && !ref_select_internal && low_power_sel
		&& !debug_background_mode && !stop_req) [*3] |-> mode_state == 3'h5) else $error("low power not entered");
	switch_wait_a: assert property ($changed(clock_select) |=> $stable(active_source) [*3])
		else $error("source switched early");
	relock_a: assert property ($changed(ref_select_internal) |-> ##[2:100] loop_relock) else $error("no relock");
	cover property (stp);
	cover property (mode_state == 3'h5);
	cover property (loop_relock);
endmodule
bind ics_clock_unit ics_props u_props (.*);

// ==== tb/testbench.sv ====
// self-checking bench for the clock mode controller
`timescale 1ns/10ps
module testbench;
	logic       clock = 1'b0, sys_rst = 1'b1, int_alive = 1'b1, stop_req = 1'b0;
	logic       ref_select_internal = 1'b1, low_power_sel = 1'b0, debug_background_mode = 1'b0;
	logic       int_ref_clock_en = 1'b0, int_ref_stop_en = 1'b0, ext_ref_clock_en = 1'b0, ext_ref_stop_en = 1'b0;
	logic [1:0] clock_select = 2'h0, bus_divider = 2'h0, active_source;
	logic [2:0] ref_divider = 3'h0, loop_ref_divider, mode_state, v;
	logic       int_ref_tick, ext_ref_tick, loop_tick, div_ref_tick, main_clock_out, bus_clock_out;
	logic       debug_lowspeed_clock, int_ref_clock_out, ext_ref_clock_out, loop_enable, loop_relock;
	int         n_fail = 0, n_checks = 0;
	ics_clock_unit uut (.*);
	ics_osc_model u_osc (.*);
	initial forever #4 clock = ~clock;
	task automatic chk(input logic [2:0] got, input logic [2:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// bounded wait for a mode, the compare after it judges the outcome
	task automatic wm(input logic [2:0] m);
		for (int i = 0; i < 300 && mode_state !== m; i++) @(negedge clock);
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#200000;
		n_fail++;
		final_report;
	end
	initial begin
		repeat (16) @(negedge clock);
		sys_rst = 1'b0;
		@(negedge clock);
		chk(mode_state, 3'h0);
		chk({1'b0, active_source}, 3'h0);
		chk({2'h0, loop_enable}, 3'h1);
		ref_divider = 3'h5;
		#1 chk(loop_ref_divider, 3'h5);
		$display("test reset done");
		@(negedge clock);
		ref_select_internal = 1'b0;
		ref_divider = 3'h2;
		wm(3'h1);
		chk(mode_state, 3'h1);
		$display("test external loop done");
		clock_select = 2'h2;
		ref_divider = 3'h3;
		low_power_sel = 1'b1;
		wm(3'h5);
		chk(mode_state, 3'h5);
		chk({1'b0, active_source}, 3'h2);
		chk({2'h0, loop_enable}, 3'h0);
		v = {1'b0, debug_lowspeed_clock, main_clock_out};
		repeat (2) @(negedge clock);
		chk({1'b0, debug_lowspeed_clock, main_clock_out}, v ^ 3'h1);
		int_alive = 1'b0;
		clock_select = 2'h1;
		repeat (100) @(negedge clock);
		chk({1'b0, active_source}, 3'h2);
		$display("test dead source done");
		int_alive = 1'b1;
		{clock_select, low_power_sel, ref_select_internal} = 4'h1;
		ref_divider = 3'h5;
		wm(3'h0);
		chk(mode_state, 3'h0);
		v = {debug_lowspeed_clock, bus_clock_out, main_clock_out};
		repeat (2) @(negedge clock);
		chk({debug_lowspeed_clock, bus_clock_out, main_clock_out}, v ^ 3'h7);
		{int_ref_clock_en, int_ref_stop_en, ext_ref_clock_en} = 3'h7;
		stop_req = 1'b1;
		wm(3'h6);
		chk(mode_state, 3'h6);
		v = {int_ref_clock_out, ext_ref_clock_out, main_clock_out};
		// internal ref ticks every 4 cycles, so its output must have flipped
		repeat (4) @(negedge clock);
		chk({int_ref_clock_out, ext_ref_clock_out, main_clock_out}, v ^ 3'h4);
		$display("test stop done");
		stop_req = 1'b0;
		final_report;
	end
endmodule
